// File: rtl/lin_frame_pkg.sv
/*
 Shared constants for the LIN diagnostic link: frame identifiers,
 service bytes, response layout, fault vector layout, timing and the
 classic checksum. Assumes a single 125 MHz clock domain.
*/
package lin_frame_pkg;
	// ========================================================
	// Frame identifiers and service bytes
	localparam logic [7:0] ID_MASTER_REQ = 8'h3c;
	localparam logic [7:0] ID_SLAVE_RSP  = 8'h3d;
	localparam logic [7:0] NAD_WILDCARD  = 8'h7f;
	localparam logic [7:0] NAD_SLEEP     = 8'h00;
	localparam logic [7:0] PCI_RESET     = 8'h01;
	localparam logic [7:0] SID_RESET     = 8'hb5;
	localparam logic [7:0] PCI_RESET_RSP = 8'h06;
	localparam logic [7:0] RSID_RESET    = 8'hf5;
	localparam logic [7:0] FILL_BYTE     = 8'hff;
	localparam int         FRAME_DATA    = 8;
	localparam logic [3:0] LAST_IDX      = 4'h9;
	// ========================================================
	// Channel and fault vector layout
	localparam int CHANNELS = 8;
	localparam int CH_FOUR  = 3;
	localparam int CH_EIGHT = 7;
	localparam int FLT_OC   = 0;
	localparam int FLT_OL   = 8;
	localparam int FLT_LOT  = 10;
	localparam int FLT_GTSD = 12;
	localparam int FLT_UV   = 13;
	localparam int FLT_W    = 14;
	localparam logic [2:0] ERR_RESET = 3'h1;
	// ========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int OC_DELAY_NS   = 10000;
	localparam int OC_DELAY_CYC  =
		(OC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RSP_TIMEOUT_CYC = 32;
	// ========================================================
	// Controller register map and fields
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_STATUS   = 8'h04;
	localparam logic [7:0] REG_RESP_LO  = 8'h08;
	localparam logic [7:0] REG_RESP_HI  = 8'h0c;
	localparam logic [7:0] REG_IRQ_STAT = 8'h10;
	localparam logic [7:0] REG_IRQ_EN   = 8'h14;
	localparam logic [7:0] REG_IRQ_CLR  = 8'h18;
	localparam logic [1:0] KIND_RESET   = 2'h0;
	localparam logic [1:0] KIND_SLEEP   = 2'h1;
	localparam logic [1:0] KIND_POLL    = 2'h2;
	localparam int IRQ_DONE  = 0;
	localparam int IRQ_ERROR = 1;

	function automatic logic [7:0] classic_checksum(
		input logic [63:0] d);
		logic [8:0] s;
		s = 9'h000;
		for (int i = 0; i < FRAME_DATA; i++) begin
			s = {1'b0, s[7:0]} + {1'b0, d[8*i +: 8]} + {8'h00, s[8]};
		end
		s = {1'b0, s[7:0]} + {8'h00, s[8]};
		return ~s[7:0];
	endfunction
endpackage

// File: rtl/lin_link_if.sv
/*
 Byte-level LIN link between the bus master and the driver node.
 Assumes both ends run on sys_clk; one byte per valid cycle.
*/
`timescale 1ns/1ps
interface lin_link_if;
	logic       req_valid;
	logic       req_start;
	logic [7:0] req_data;
	logic       rsp_valid;
	logic [7:0] rsp_data;

	modport master (output req_valid, req_start, req_data,
		input rsp_valid, rsp_data);
	modport node (input req_valid, req_start, req_data,
		output rsp_valid, rsp_data);
endinterface

// File: rtl/lin_driver_node.sv
/*
 Driver node end: decodes targeted reset, broadcast reset and sleep
 frames, answers the reset from the prime node, and runs output fault
 handling for eight low-side channels. Assumes fault inputs come from
 analog comparators outside the clock domain and that set commands
 come from logic on sys_clk.
*/
// Function
// - Reset request: 3C, NAD, 01, B5, FF fill
// - Valid reset turns every output off
// - Reset clears error bits 1,2, sets 0
// - All nodes sharing address switch off
// - Reply 3D: NAD, 06, F5, identity bytes
// - Only prime node transmits reset reply
// - First data byte zero means sleep
// - Sleep accepted whatever other bytes hold
// - Open load only channels four, eight, off
// - Open load shown off only, self clearing
// - Overcurrent turns driver off after delay
// - Overcurrent latch released by off command
// - Local overtemperature latches, fault info masked by global
// - Local fault clears after cool, off command
// - Global shutdown forces off, not latched
// - Undervoltage blocks frame decode and set commands
// - Overcurrent on all eight channels
// - Broadcast 7F resets all, no reply
`timescale 1ns/1ps
module lin_driver_node #(
	parameter logic [7:0]  NODE_NAD     = 8'h4a,    // Arbitrary value
	parameter bit          PRIME        = 1'b1,
	parameter logic [15:0] SUPPLIER_ID  = 16'h5a5a, // Arbitrary value
	parameter logic [15:0] FUNCTION_ID  = 16'h1234, // Arbitrary value
	parameter logic [7:0]  SILICON_VER  = 8'h01,    // Arbitrary value
	parameter int          OC_DELAY_CYC = lin_frame_pkg::OC_DELAY_CYC
) (
	input  wire logic       sys_clk,
	input  wire logic       srst,
	lin_link_if.node        link,
	input  wire logic       set_cmd_valid,
	input  wire logic [7:0] set_cmd_data,
	input  wire logic [7:0] overcurrent,
	input  wire logic [1:0] open_load,
	input  wire logic [1:0] local_overtemp,
	input  wire logic       thermal_shutdown,
	input  wire logic       undervoltage,
	output logic      [7:0] driver_on,
	output logic      [7:0] output_status,
	output logic      [3:0] application_fault_info,
	output logic      [2:0] error_status,
	output logic            sleep_mode
);
	localparam int CW = 16;

	// ========================================================
	// Fault input synchronisers
	logic [lin_frame_pkg::FLT_W-1:0] s1_reg, s2_reg, s3_reg, flt_reg;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s1_reg  <= '0;
			s2_reg  <= '0;
			s3_reg  <= '0;
			flt_reg <= '0;
		end else begin
			s1_reg  <= {undervoltage, thermal_shutdown, local_overtemp,
				open_load, overcurrent};
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			flt_reg <= (s2_reg & s3_reg) | (flt_reg & (s2_reg | s3_reg));
		end
	end
	logic [7:0] oc_in;
	logic [1:0] ol_in, lot_in;
	logic       gtsd_in, uv_in;
	assign oc_in   = flt_reg[lin_frame_pkg::FLT_OC +: 8];
	assign ol_in   = flt_reg[lin_frame_pkg::FLT_OL +: 2];
	assign lot_in  = flt_reg[lin_frame_pkg::FLT_LOT +: 2];
	assign gtsd_in = flt_reg[lin_frame_pkg::FLT_GTSD];
	assign uv_in   = flt_reg[lin_frame_pkg::FLT_UV];

	// ========================================================
	// Frame receiver
	logic [3:0] rx_idx_reg;
	logic [7:0] frame_reg [0:7];
	logic [63:0] frame_vec;
	logic       rx_last, frame_ok, is_sleep, is_reset, addr_own;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			frame_vec[8*i +: 8] = frame_reg[i];
		end
	end
	assign rx_last  = link.req_valid && !link.req_start &&
		rx_idx_reg == lin_frame_pkg::LAST_IDX;
	assign frame_ok = rx_last && !uv_in &&
		link.req_data == lin_frame_pkg::classic_checksum(frame_vec);
	assign addr_own = frame_reg[0] == NODE_NAD;
	assign is_sleep = frame_ok &&
		frame_reg[0] == lin_frame_pkg::NAD_SLEEP;
	assign is_reset = frame_ok &&
		(addr_own || frame_reg[0] == lin_frame_pkg::NAD_WILDCARD) &&
		frame_reg[1] == lin_frame_pkg::PCI_RESET &&
		frame_reg[2] == lin_frame_pkg::SID_RESET &&
		(&frame_vec[63:24]);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rx_idx_reg <= 4'h0;
		end else if (link.req_valid && link.req_start) begin
			rx_idx_reg <= (link.req_data == lin_frame_pkg::ID_MASTER_REQ &&
				!uv_in) ? 4'h1 : 4'h0;
		end else if (link.req_valid && rx_idx_reg != 4'h0) begin
			rx_idx_reg <= rx_last ? 4'h0 : rx_idx_reg + 4'h1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			for (int i = 0; i < 8; i++) begin
				frame_reg[i] <= 8'h00;
			end
		end else if (link.req_valid && !link.req_start &&
			rx_idx_reg != 4'h0 && !rx_last) begin
			frame_reg[rx_idx_reg[2:0] - 3'h1] <= link.req_data;
		end
	end

	// ========================================================
	// Mode, command and error flags
	logic [7:0] cmd_reg;
	logic       pend_reg;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cmd_reg <= 8'h00;
		end else if (is_reset || is_sleep) begin
			cmd_reg <= 8'h00;
		end else if (set_cmd_valid && !uv_in) begin
			cmd_reg <= set_cmd_data;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sleep_mode <= 1'b0;
		end else if (is_sleep) begin
			sleep_mode <= 1'b1;
		end else if (link.req_valid && link.req_start) begin
			sleep_mode <= 1'b0;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			error_status <= 3'h0;
		end else if (is_reset) begin
			error_status <= lin_frame_pkg::ERR_RESET;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pend_reg <= 1'b0;
		end else if (is_reset) begin
			pend_reg <= PRIME && addr_own;
		end else if (frame_ok || (link.req_valid && link.req_start &&
			link.req_data == lin_frame_pkg::ID_SLAVE_RSP)) begin
			pend_reg <= 1'b0;
		end
	end

	// ========================================================
	// Fault handling
	logic [7:0]    oc_lat_reg;
	logic [1:0]    lot_lat_reg;
	logic [CW-1:0] oc_cnt_reg [0:7];
	logic [7:0]    drive;
	assign drive = cmd_reg & ~oc_lat_reg & {8{~(|lot_lat_reg)}} &
		{8{~gtsd_in & ~sleep_mode}};
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : gen_oc
			always_ff @(posedge sys_clk) begin
				if (srst || !(oc_in[g] && drive[g])) begin
					oc_cnt_reg[g] <= '0;
				end else if (oc_cnt_reg[g] != CW'(OC_DELAY_CYC)) begin
					oc_cnt_reg[g] <= oc_cnt_reg[g] + 1'b1;
				end
			end
			always_ff @(posedge sys_clk) begin
				if (srst) begin
					oc_lat_reg[g] <= 1'b0;
				end else if (oc_cnt_reg[g] == CW'(OC_DELAY_CYC) &&
					oc_in[g] && drive[g]) begin
					oc_lat_reg[g] <= 1'b1;
				end else if (!cmd_reg[g]) begin
					oc_lat_reg[g] <= 1'b0;
				end
			end
		end
		for (g = 0; g < 2; g++) begin : gen_lot
			localparam int CH = (g == 0) ? lin_frame_pkg::CH_FOUR :
				lin_frame_pkg::CH_EIGHT;
			always_ff @(posedge sys_clk) begin
				if (srst) begin
					lot_lat_reg[g] <= 1'b0;
				end else if (lot_in[g]) begin
					lot_lat_reg[g] <= 1'b1;
				end else if (!cmd_reg[CH]) begin
					lot_lat_reg[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ========================================================
	// Driver and status outputs
	logic [7:0] stat_next;
	always_comb begin
		stat_next = oc_lat_reg;
		stat_next[lin_frame_pkg::CH_FOUR] = oc_lat_reg[lin_frame_pkg::CH_FOUR]
			| lot_lat_reg[0] | (ol_in[0] & ~drive[lin_frame_pkg::CH_FOUR]);
		stat_next[lin_frame_pkg::CH_EIGHT] =
			oc_lat_reg[lin_frame_pkg::CH_EIGHT] | lot_lat_reg[1] |
			(ol_in[1] & ~drive[lin_frame_pkg::CH_EIGHT]);
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			driver_on              <= 8'h00;
			output_status          <= 8'h00;
			application_fault_info <= 4'h0;
		end else begin
			driver_on              <= drive;
			output_status          <= stat_next;
			application_fault_info <= {lot_lat_reg & {2{~gtsd_in}},
				oc_lat_reg[lin_frame_pkg::CH_EIGHT],
				oc_lat_reg[lin_frame_pkg::CH_FOUR]};
		end
	end

	// ========================================================
	// Reset response transmitter
	logic [3:0]  tx_idx_reg;
	logic [71:0] rsp_vec;
	assign rsp_vec = {8'h00, SILICON_VER, FUNCTION_ID, SUPPLIER_ID,
		lin_frame_pkg::RSID_RESET, lin_frame_pkg::PCI_RESET_RSP,
		NODE_NAD};
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tx_idx_reg     <= 4'h0;
			link.rsp_valid <= 1'b0;
			link.rsp_data  <= 8'h00;
		end else if (tx_idx_reg == 4'h0 && link.req_valid &&
			link.req_start && pend_reg &&
			link.req_data == lin_frame_pkg::ID_SLAVE_RSP) begin
			tx_idx_reg     <= 4'h1;
			link.rsp_valid <= 1'b1;
			link.rsp_data  <= rsp_vec[7:0];
		end else if (tx_idx_reg != 4'h0 && tx_idx_reg != 4'h9) begin
			tx_idx_reg     <= tx_idx_reg + 4'h1;
			link.rsp_valid <= 1'b1;
			link.rsp_data  <= (tx_idx_reg == 4'h8) ?
				lin_frame_pkg::classic_checksum(rsp_vec[63:0]) :
				rsp_vec[8*tx_idx_reg +: 8];
		end else begin
			tx_idx_reg     <= 4'h0;
			link.rsp_valid <= 1'b0;
			link.rsp_data  <= 8'h00;
		end
	end
endmodule

// File: rtl/lin_bus_master.sv
/*
 Bus master end: sends reset, sleep and response-poll frames on
 software order and collects the slave reply. Assumes a plain register
 port on sys_clk and a node end answering within the timeout.
*/
`timescale 1ns/1ps
module lin_bus_master #(
	parameter int TIMEOUT_CYC = lin_frame_pkg::RSP_TIMEOUT_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        srst,
	lin_link_if.master       link,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	output logic             irq
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_SEND = 4'b0010,
		ST_WAIT = 4'b0100,
		ST_RECV = 4'b1000
	} state_type;

	// ========================================================
	// Frame sender and reply collector
	state_type   state_reg;
	logic [79:0] tx_reg;
	logic [3:0]  idx_reg, len_reg;
	logic [7:0]  tmo_reg;
	logic [71:0] rx_reg;
	logic        ok_reg, start;
	logic [63:0] body;
	assign start = wr && addr == lin_frame_pkg::REG_CTRL &&
		state_reg == ST_IDLE;
	always_comb begin
		body = {{5{lin_frame_pkg::FILL_BYTE}}, lin_frame_pkg::SID_RESET,
			lin_frame_pkg::PCI_RESET, wdata[7:0]};
		if (wdata[9:8] == lin_frame_pkg::KIND_SLEEP) begin
			body = {{7{lin_frame_pkg::FILL_BYTE}},
				lin_frame_pkg::NAD_SLEEP};
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_reg <= ST_IDLE;
			tx_reg    <= '0;
			idx_reg   <= 4'h0;
			len_reg   <= 4'h0;
			tmo_reg   <= 8'h00;
			rx_reg    <= '0;
			ok_reg    <= 1'b0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (start) begin
						idx_reg   <= 4'h0;
						state_reg <= ST_SEND;
						if (wdata[9:8] == lin_frame_pkg::KIND_POLL) begin
							tx_reg  <= {72'h0, lin_frame_pkg::ID_SLAVE_RSP};
							len_reg <= 4'h0;
						end else begin
							tx_reg  <= {lin_frame_pkg::classic_checksum(body),
								body, lin_frame_pkg::ID_MASTER_REQ};
							len_reg <= lin_frame_pkg::LAST_IDX;
						end
					end
				end
				ST_SEND: begin
					tx_reg  <= tx_reg >> 8;
					idx_reg <= idx_reg + 4'h1;
					tmo_reg <= 8'h00;
					if (idx_reg == len_reg) begin
						idx_reg   <= 4'h0;
						state_reg <= (len_reg == 4'h0) ? ST_WAIT : ST_IDLE;
						ok_reg    <= len_reg != 4'h0;
					end
				end
				ST_WAIT: begin
					tmo_reg <= tmo_reg + 8'h01;
					if (link.rsp_valid) begin
						rx_reg    <= {link.rsp_data, rx_reg[71:8]};
						idx_reg   <= 4'h1;
						state_reg <= ST_RECV;
					end else if (tmo_reg == 8'(TIMEOUT_CYC)) begin
						ok_reg    <= 1'b0;
						state_reg <= ST_IDLE;
					end
				end
				ST_RECV: begin
					if (link.rsp_valid) begin
						rx_reg  <= {link.rsp_data, rx_reg[71:8]};
						idx_reg <= idx_reg + 4'h1;
					end
					if (!link.rsp_valid || idx_reg == 4'h8) begin
						ok_reg <= link.rsp_valid && idx_reg == 4'h8 &&
							link.rsp_data ==
							lin_frame_pkg::classic_checksum(rx_reg[71:8]);
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
	// ========================================================
	// Link outputs
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			link.req_valid <= 1'b0;
			link.req_start <= 1'b0;
			link.req_data  <= 8'h00;
		end else begin
			link.req_valid <= state_reg == ST_SEND;
			link.req_start <= state_reg == ST_SEND && idx_reg == 4'h0;
			link.req_data  <= tx_reg[7:0];
		end
	end

	// ========================================================
	// Interrupt flags and register reads
	logic       busy_q;
	logic [1:0] irq_stat_reg, irq_en_reg, ev;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= state_reg != ST_IDLE;
		end
	end
	assign ev[lin_frame_pkg::IRQ_DONE]  = busy_q && state_reg == ST_IDLE;
	assign ev[lin_frame_pkg::IRQ_ERROR] = ev[lin_frame_pkg::IRQ_DONE] &&
		!ok_reg;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			irq_stat_reg <= 2'h0;
			irq_en_reg   <= 2'h0;
		end else begin
			irq_stat_reg <= ev | (irq_stat_reg &
				~((wr && addr == lin_frame_pkg::REG_IRQ_CLR) ?
				wdata[1:0] : 2'h0));
			if (wr && addr == lin_frame_pkg::REG_IRQ_EN) begin
				irq_en_reg <= wdata[1:0];
			end
		end
	end
	assign irq = |(irq_stat_reg & irq_en_reg);
	always_ff @(posedge sys_clk) begin
		if (srst || !rd) begin
			rdata <= 32'h0000_0000;
		end else begin
			case (addr)
				lin_frame_pkg::REG_STATUS:
					rdata <= {30'h0, ok_reg, state_reg != ST_IDLE};
				lin_frame_pkg::REG_RESP_LO:  rdata <= rx_reg[31:0];
				lin_frame_pkg::REG_RESP_HI:  rdata <= rx_reg[63:32];
				lin_frame_pkg::REG_IRQ_STAT: rdata <= {30'h0, irq_stat_reg};
				lin_frame_pkg::REG_IRQ_EN:   rdata <= {30'h0, irq_en_reg};
				default:                     rdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule

// File: bench/lin_reset_sleep_fault_handler_chk.sv
/*
 Link checker: request framing, reply layout and output shut-off.
 Assumes it sits beside the link joining master and driver node.
*/
`timescale 1ns/1ps
module lin_reset_sleep_fault_handler_chk #(
	parameter logic [7:0] NODE_NAD = 8'h4a
) (
	input  wire logic       sys_clk,
	input  wire logic       srst,
	input  wire logic       req_valid,
	input  wire logic       req_start,
	input  wire logic [7:0] req_data,
	input  wire logic       rsp_valid,
	input  wire logic [7:0] rsp_data,
	input  wire logic [7:0] driver_on,
	input  wire logic [2:0] error_status,
	input  wire logic       sleep_mode,
	input  wire logic       thermal_shutdown
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	// ========================================================
	// Request frames
	AST_START_ID: assert property (
		req_start |-> req_valid && (req_data == 8'h3c || req_data == 8'h3d))
		else $error("frame start without identifier");
	AST_FRAME_LEN: assert property (
		req_start && req_data == 8'h3c |=>
		(req_valid && !req_start) [*8] ##1 req_valid)
		else $error("request frame not ten bytes");
	AST_RESET_LAYOUT: assert property (
		(req_start && req_data == 8'h3c) ##1 (req_data != 8'h00) |=>
		req_data == 8'h01 ##1 req_data == 8'hb5 ##1 (req_data == 8'hff) [*5])
		else $error("reset request layout wrong");
	// ========================================================
	// Reply frames
	AST_RSP_HEAD: assert property (
		$rose(rsp_valid) |-> rsp_data == NODE_NAD ##1 rsp_data == 8'h06
		##1 rsp_data == 8'hf5)
		else $error("reply header wrong");
	AST_RSP_LEN: assert property (
		$rose(rsp_valid) |-> rsp_valid [*8] ##1 rsp_valid ##1 !rsp_valid)
		else $error("reply not nine bytes");
	AST_RSP_AFTER_POLL: assert property (
		$rose(rsp_valid) |-> $past(req_valid) && $past(req_start) &&
		$past(req_data) == 8'h3d)
		else $error("reply without poll header");
	// ========================================================
	// Output shut-off
	AST_RESET_OFF: assert property (
		error_status == 3'h1 && $past(error_status) != 3'h1 |->
		##[1:2] driver_on == 8'h00)
		else $error("outputs on after reset");
	AST_SLEEP_OFF: assert property (
		sleep_mode |=> driver_on == 8'h00)
		else $error("outputs on in sleep");
	AST_SHUTDOWN_OFF: assert property (
		thermal_shutdown [*7] |-> driver_on == 8'h00)
		else $error("outputs on in thermal shutdown");
endmodule

// File: bench/lin_reset_sleep_fault_handler_test.sv
/*
 Self-checking bench: bus master and driver node joined by the link.
 Assumes the package, link interface and checker are compiled first.
*/
`timescale 1ns/1ps
module lin_reset_sleep_fault_handler_test;
	localparam logic [7:0]  NAD = 8'h4a;
	localparam logic [15:0] SUP = 16'h1b2c; // Arbitrary value
	localparam logic [15:0] FUN = 16'h3d4e; // Arbitrary value
	localparam logic [7:0]  VER = 8'h05;    // Arbitrary value
	logic        sys_clk, srst, wr, rd, irq, set_cmd_valid, rd_d;
	logic        thermal_shutdown, undervoltage, sleep_mode;
	logic [7:0]  addr, set_cmd_data, overcurrent, driver_on, p;
	logic [7:0]  output_status;
	logic [1:0]  open_load, local_overtemp;
	logic [3:0]  application_fault_info;
	logic [2:0]  error_status;
	logic [31:0] wdata, rdata, seed, rexp;
	logic [31:0] q[$];
	int          mismatches, checks;
	lin_link_if link();
	lin_bus_master lin_bus_master_i (.sys_clk(sys_clk), .srst(srst),
		.link(link), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .irq(irq));
	lin_driver_node #(.NODE_NAD(NAD), .PRIME(1'b1), .SUPPLIER_ID(SUP),
		.FUNCTION_ID(FUN), .SILICON_VER(VER), .OC_DELAY_CYC(4))
		lin_driver_node_i (.sys_clk(sys_clk), .srst(srst), .link(link),
		.set_cmd_valid(set_cmd_valid), .set_cmd_data(set_cmd_data),
		.overcurrent(overcurrent), .open_load(open_load),
		.local_overtemp(local_overtemp),
		.thermal_shutdown(thermal_shutdown), .undervoltage(undervoltage),
		.driver_on(driver_on), .output_status(output_status),
		.application_fault_info(application_fault_info),
		.error_status(error_status), .sleep_mode(sleep_mode));
	lin_reset_sleep_fault_handler_chk #(.NODE_NAD(NAD))
		lin_reset_sleep_fault_handler_chk_i (.sys_clk(sys_clk),
		.srst(srst), .req_valid(link.req_valid),
		.req_start(link.req_start), .req_data(link.req_data),
		.rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data),
		.driver_on(driver_on), .error_status(error_status),
		.sleep_mode(sleep_mode), .thermal_shutdown(thermal_shutdown));
	// ========================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic end_sim();
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t read %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t output %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
	endtask
	task automatic wait_irq();
		for (int i = 0; i < 400; i++) begin
			@(posedge sys_clk);
			if (irq === 1'b1)
				return;
		end
		mismatches++;
		$display("MISMATCH %0t no interrupt", $time);
		end_sim();
	endtask
	task automatic set_cmd(input logic [7:0] d);
		@(posedge sys_clk);
		set_cmd_valid <= 1'b1;
		set_cmd_data <= d;
		@(posedge sys_clk);
		set_cmd_valid <= 1'b0;
		wt(3);
	endtask
	task automatic frame(input logic [1:0] k, input logic [7:0] n,
		input logic [31:0] en);
		wr_reg(lin_frame_pkg::REG_IRQ_EN, en);
		wr_reg(lin_frame_pkg::REG_CTRL, {22'h0, k, n});
		wait_irq();
		if (en == 32'h0000_0001)
			rd_reg(lin_frame_pkg::REG_IRQ_STAT, 32'h0000_0001);
		wr_reg(lin_frame_pkg::REG_IRQ_CLR, 32'h0000_0003);
		wt(2);
		cmp8({7'h00, irq}, 8'h00);
	endtask
	// ========================================================
	// Clock and read monitor
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
		rd_d <= rd;
	always @(negedge sys_clk)
		if (rd_d === 1'b1 && q.size() > 0) begin
			rexp = q.pop_front();
			cmp32(rdata, rexp);
		end
	// ========================================================
	// Main sequence
	initial begin
		srst = 1'b1;
		{wr, rd, set_cmd_valid, thermal_shutdown, undervoltage} = '0;
		{addr, wdata, set_cmd_data, overcurrent, p} = '0;
		{open_load, local_overtemp} = '0;
		{mismatches, checks} = '0;
		seed = 32'h0001_680b;
		repeat (20) @(posedge sys_clk);
		srst <= 1'b0;
		wt(2);
		cmp8(driver_on, 8'h00);
		cmp8({5'h00, error_status}, 8'h00);
		rd_reg(8'hfc, 32'h0000_0000);
		// Undervoltage freezes outputs and blocks frames
		p = 8'(rnd()) | 8'h01;
		set_cmd(p);
		@(posedge sys_clk);
		undervoltage <= 1'b1;
		wt(8);
		set_cmd(~p);
		frame(lin_frame_pkg::KIND_RESET, NAD, 32'h0000_0001);
		cmp8(driver_on, p);
		cmp8({5'h00, error_status}, 8'h00);
		undervoltage <= 1'b0;
		wt(8);
		cmp8(driver_on, p);
		// Targeted reset and reply
		set_cmd(8'hff);
		frame(lin_frame_pkg::KIND_RESET, NAD, 32'h0000_0001);
		cmp8(driver_on, 8'h00);
		cmp8({5'h00, error_status}, 8'h01);
		frame(lin_frame_pkg::KIND_POLL, NAD, 32'h0000_0001);
		rd_reg(lin_frame_pkg::REG_RESP_LO, {SUP[7:0], 8'hf5, 8'h06, NAD});
		rd_reg(lin_frame_pkg::REG_RESP_HI, {VER, FUN, SUP[15:8]});
		rd_reg(lin_frame_pkg::REG_STATUS, 32'h0000_0002);
		// Broadcast reset: outputs off, no reply
		set_cmd(8'(rnd()) | 8'h01);
		frame(lin_frame_pkg::KIND_RESET, 8'h7f, 32'h0000_0001);
		cmp8(driver_on, 8'h00);
		frame(lin_frame_pkg::KIND_POLL, NAD, 32'h0000_0002);
		rd_reg(lin_frame_pkg::REG_STATUS, 32'h0000_0000);
		// Sleep, then a masked frame to another address
		p = 8'(rnd()) | 8'h01;
		set_cmd(p);
		frame(lin_frame_pkg::KIND_SLEEP, 8'h00, 32'h0000_0001);
		cmp8({7'h00, sleep_mode}, 8'h01);
		cmp8(driver_on, 8'h00);
		set_cmd(p);
		cmp8(driver_on, 8'h00);
		wr_reg(lin_frame_pkg::REG_IRQ_EN, 32'h0000_0000);
		wr_reg(lin_frame_pkg::REG_CTRL, {24'h0, 8'h20 | (8'(rnd()) & 8'h0f)});
		wt(40);
		cmp8({7'h00, irq}, 8'h00);
		rd_reg(lin_frame_pkg::REG_IRQ_STAT, 32'h0000_0001);
		wr_reg(lin_frame_pkg::REG_IRQ_EN, 32'h0000_0001);
		wt(2);
		cmp8({7'h00, irq}, 8'h01);
		wr_reg(lin_frame_pkg::REG_IRQ_CLR, 32'h0000_0001);
		wt(2);
		cmp8({7'h00, irq}, 8'h00);
		cmp8(driver_on, p);
		cmp8({7'h00, sleep_mode}, 8'h00);
		// Overcurrent latch on every channel
		for (int c = 0; c < 8; c++) begin
			set_cmd(8'hff);
			@(posedge sys_clk);
			overcurrent <= 8'h01 << c;
			wt(12);
			overcurrent <= 8'h00;
			wt(8);
			cmp8(driver_on, ~(8'h01 << c));
			cmp8(output_status, 8'h01 << c);
			cmp8({4'h0, application_fault_info}, {6'h00, c == 7, c == 3});
			set_cmd(~(8'h01 << c));
			set_cmd(8'hff);
			cmp8(driver_on, 8'hff);
		end
		// Open load on channels four and eight
		for (int j = 0; j < 2; j++) begin
			set_cmd(j ? 8'h7f : 8'hf7);
			@(posedge sys_clk);
			open_load <= 2'(j + 1);
			wt(8);
			cmp8(output_status, j ? 8'h80 : 8'h08);
			cmp8({4'h0, application_fault_info}, 8'h00);
			set_cmd(8'hff);
			wt(4);
			cmp8(output_status, 8'h00);
			open_load <= 2'b00;
		end
		// Local overtemperature masked by global shutdown
		@(posedge sys_clk);
		local_overtemp <= 2'b10;
		thermal_shutdown <= 1'b1;
		wt(8);
		cmp8({4'h0, application_fault_info}, 8'h00);
		cmp8(driver_on, 8'h00);
		thermal_shutdown <= 1'b0;
		local_overtemp <= 2'b00;
		wt(8);
		cmp8({4'h0, application_fault_info}, 8'h08);
		cmp8(output_status, 8'h80);
		cmp8(driver_on, 8'h00);
		set_cmd(8'h7f);
		cmp8(driver_on, 8'h7f);
		// Global shutdown restores the programmed state
		p = 8'(rnd()) | 8'h01;
		set_cmd(p);
		@(posedge sys_clk);
		thermal_shutdown <= 1'b1;
		wt(8);
		cmp8(driver_on, 8'h00);
		thermal_shutdown <= 1'b0;
		wt(8);
		cmp8(driver_on, p);
		end_sim();
	end
endmodule
